/* src/wdc_fifo.sv */
`timescale 1ns/1ps
module wdc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  // Storage, pointers and fill level
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
  } wdc_fifo_state_type;

  wdc_fifo_state_type q;
  wdc_fifo_state_type d;
  logic push;
  logic pop;

  // Full and empty come straight from the fill level
  assign o_ready = (q.cnt != (AW+1)'(DEPTH));
  assign o_valid = (q.cnt != '0);
  assign o_data = q.mem[q.rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = i_data;
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
    // Simultaneous push and pop leaves the level unchanged
    case ({push, pop})
      2'h2: d.cnt = q.cnt + 1'b1;
      2'h1: d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

/* src/wdc_map.svh */
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH

// Serial word and address widths
`define WDC_ADDR_W 15
`define WDC_WORD_W 16
// Configuration register window: indexes 0 .. REG_NUM-1
`define WDC_REG_NUM 15'h0010
`define WDC_REG_IDX_W 4
`define WDC_REG_RESET 16'h0000
// Shadow transfer register and its update bit
`define WDC_XFER_ADDR 15'h001D
`define WDC_UPDATE_BIT 0
// Pattern memory window
`define WDC_MEM_BASE 15'h6000
`define WDC_MEM_LAST 15'h6FFF
`define WDC_MEM_AW 12
`define WDC_MEM_DW 12
// Memory entry sits in the upper bits of the data word
`define WDC_MEM_LSB 4
// Write FIFO toward the pattern memory
`define WDC_FIFO_DEPTH 16
`define WDC_FIFO_W 24
// Bit counter values at which a word is complete
`define WDC_BITS_LAST 5'h0F
`define WDC_BITS_LAST_DBL 5'h0E

`endif

/* src/wdc_pkg.sv */
package wdc_pkg;
  `include "wdc_map.svh"

  // Frame phases, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_HDR  = 3'h2,
    PH_DATA = 3'h4
  } wdc_phase_type;

  // Whole state of the serial port
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic sdi_s1;
    logic sdi_s2;
    logic mpi_s1;
    logic mpi_s2;
    wdc_phase_type phase;
    logic rw;
    logic [4:0] bitcnt;
    logic [`WDC_ADDR_W-1:0] addr;
    logic [`WDC_WORD_W-1:0] shreg;
    logic [`WDC_WORD_W-1:0] txreg;
    logic dout;
    logic [15:0][`WDC_WORD_W-1:0] shadow;
    logic [15:0][`WDC_WORD_W-1:0] active;
    logic armed;
    logic pend_valid;
    logic [`WDC_FIFO_W-1:0] pend_word;
    logic ovf;
  } wdc_state_type;
endpackage

/* src/wdc_spi_port.sv */
// Contract
// - Transaction framed while chip select is low
// - First serial bit: high read, low write
// - Then 15-bit start address, latched first
// - Address auto-increments per further word
// - Write keeps data line an input
// - Read drives register data after address
// - Read MSB first, 3-wire or 4-wire
// - Chip select high ends transfer, stops burst
// - Pattern memory at 0x6000 to 0x6FFF
// - Double-rate: multipurpose pin second write input
// - Configuration registers are shadow plus active
// - Writing update bit one arms transfer
// - Armed copy happens when pattern generator off
// - Memory writes bypass the shadow transfer
// - 4-wire reads return on multipurpose pin (code uses the data line instead when double-rate is set)
// - Reset pin restores every register default
`timescale 1ns/1ps
`include "wdc_map.svh"

module wdc_spi_port (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  input wire logic i_multipurpose_serial_pin,
  output logic o_multipurpose_serial_pin,
  output logic o_multipurpose_serial_pin_oe,
  input wire logic i_four_wire,
  input wire logic i_double_rate,
  input wire logic i_pattern_off,
  output logic [255:0] o_active_regs,
  output logic o_update_armed,
  output logic o_mem_valid,
  input wire logic i_mem_ready,
  output logic [`WDC_MEM_AW-1:0] o_mem_addr,
  output logic [`WDC_MEM_DW-1:0] o_mem_data,
  output logic o_mem_overflow
);
  // Reset value of the whole state; chip select idles high
  localparam wdc_pkg::wdc_state_type ST_RST = '{
    phase: wdc_pkg::PH_IDLE,
    cs_s1: 1'h1,
    cs_s2: 1'h1,
    default: '0
  };

  logic rst_q1; // First stage of the reset release
  logic rst_n; // Released reset used everywhere else
  wdc_pkg::wdc_state_type q; // Registered state
  wdc_pkg::wdc_state_type d; // Next state
  logic sclk_rise; // Serial clock rising edge seen
  logic sclk_fall; // Serial clock falling edge seen
  logic frame_on; // Chip select held low
  logic dbl_wr; // Two bits per serial clock this word
  logic use_mpin; // Read data leaves on the multipurpose pin
  logic hdr_done; // Last header bit arrives now
  logic word_done; // Last bit of a data word arrives now
  logic wr_commit; // Completed write word to store
  logic is_mem; // Current address lies in pattern memory
  logic [`WDC_ADDR_W-1:0] hdr_addr; // Start address as assembled
  logic [`WDC_ADDR_W-1:0] addr_next; // Following address of a burst
  logic [`WDC_WORD_W-1:0] wr_word; // Write word including the last bits
  logic fifo_in_ready; // FIFO can take the pending memory word
  logic [`WDC_FIFO_W-1:0] fifo_out; // Address and data toward memory
  logic tx_msb; // Next bit to shift out

  // Read-back: shadow copy, the armed flag, zero elsewhere
  function automatic logic [`WDC_WORD_W-1:0] rd_word(
    input logic [`WDC_ADDR_W-1:0] a,
    input logic [15:0][`WDC_WORD_W-1:0] sh,
    input logic armed
  );
    logic [`WDC_WORD_W-1:0] w;
    w = '0;
    if (a < `WDC_REG_NUM) begin
      w = sh[a[`WDC_REG_IDX_W-1:0]];
    end else if (a == `WDC_XFER_ADDR) begin
      w[`WDC_UPDATE_BIT] = armed;
    end
    // Memory reads return zero: the entries live outside this port
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  // Release is synchronous so no state flop sees reset drop close to an edge
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_q1 <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_q1 <= 1'h1;
      rst_n <= rst_q1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decodes on the synchronised pins
  assign sclk_rise = q.sclk_s2 & ~q.sclk_s3;
  assign sclk_fall = ~q.sclk_s2 & q.sclk_s3;
  assign frame_on = ~q.cs_s2;
  assign dbl_wr = i_double_rate & ~q.rw;
  assign use_mpin = i_four_wire & ~i_double_rate;
  assign hdr_addr = {q.shreg[13:0], q.sdi_s2};
  assign hdr_done = frame_on & sclk_rise & (q.phase == wdc_pkg::PH_HDR) &
                    (q.bitcnt == `WDC_BITS_LAST);
  // Second input bit follows the data line bit in double-rate mode
  assign wr_word = dbl_wr ? {q.shreg[13:0], q.sdi_s2, q.mpi_s2} :
                            {q.shreg[14:0], q.sdi_s2};
  // Double rate moves two bits per rise, so such a word ends on count 14
  assign word_done = frame_on & sclk_rise & (q.phase == wdc_pkg::PH_DATA) &
                     (q.bitcnt == (dbl_wr ? `WDC_BITS_LAST_DBL : `WDC_BITS_LAST));
  assign wr_commit = word_done & ~q.rw;
  assign addr_next = q.addr + 15'h0001;
  assign is_mem = (q.addr >= `WDC_MEM_BASE) && (q.addr <= `WDC_MEM_LAST);
  assign tx_msb = q.txreg[15];

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d = q;
    // Two-flop synchronisers for every pin
    // Edge flop resets to the idle clock level, so no false edge follows reset
    d.sclk_s1 = i_sclk;
    d.sclk_s2 = q.sclk_s1;
    d.sclk_s3 = q.sclk_s2;
    d.cs_s1 = i_cs_n;
    d.cs_s2 = q.cs_s1;
    d.sdi_s1 = i_sdio;
    d.sdi_s2 = q.sdi_s1;
    d.mpi_s1 = i_multipurpose_serial_pin;
    d.mpi_s2 = q.mpi_s1;
    // Armed copy waits for the pattern generator to stop
    if (q.armed && i_pattern_off) begin
      d.active = q.shadow;
      d.armed = 1'h0;
    end
    // Pending memory word leaves once the FIFO accepts it
    if (q.pend_valid && fifo_in_ready) begin
      d.pend_valid = 1'h0;
    end
    if (!frame_on) begin
      // Chip select high drops any burst in flight
      d.phase = wdc_pkg::PH_IDLE;
      d.bitcnt = 5'h00;
      d.dout = 1'h0;
    end else begin
      case (q.phase)
        wdc_pkg::PH_IDLE: begin
          // New frame starts with the header
          // Chip select leads the first rise by a full period, so no bit is lost here
          d.phase = wdc_pkg::PH_HDR;
          d.bitcnt = 5'h00;
        end
        wdc_pkg::PH_HDR: begin
          if (sclk_rise) begin
            d.shreg = {q.shreg[14:0], q.sdi_s2};
            d.bitcnt = q.bitcnt + 5'h01;
          end
          if (hdr_done) begin
            // First bit is direction, the rest the start address
            d.rw = q.shreg[14];
            d.addr = hdr_addr;
            d.bitcnt = 5'h00;
            d.phase = wdc_pkg::PH_DATA;
            d.txreg = rd_word(hdr_addr, q.shadow, q.armed);
          end
        end
        wdc_pkg::PH_DATA: begin
          // Read data changes on the falling edge, MSB first
          if (sclk_fall && q.rw) begin
            d.dout = q.txreg[15];
            d.txreg = {q.txreg[14:0], 1'h0};
          end
          if (sclk_rise) begin
            d.shreg = wr_word;
            d.bitcnt = q.bitcnt + (dbl_wr ? 5'h02 : 5'h01);
          end
          if (word_done) begin
            d.bitcnt = 5'h00;
            d.addr = addr_next;
            if (q.rw) begin
              d.txreg = rd_word(addr_next, q.shadow, q.armed);
            end
          end
          if (wr_commit) begin
            if (q.addr < `WDC_REG_NUM) begin
              // Writes always land in the shadow set
              d.shadow[q.addr[`WDC_REG_IDX_W-1:0]] = wr_word;
            end else if (q.addr == `WDC_XFER_ADDR) begin
              // Set after the clear above, so a new arm is never lost
              if (wr_word[`WDC_UPDATE_BIT]) begin
                d.armed = 1'h1;
              end
            end else if (is_mem) begin
              // Into the pending word ahead of the FIFO, never through the shadow set
              // Overflow stays set until reset, so a lost entry is still visible later
              if (d.pend_valid) begin
                d.ovf = 1'h1;
              end else begin
                d.pend_valid = 1'h1;
                d.pend_word = {q.addr[`WDC_MEM_AW-1:0],
                               wr_word[`WDC_WORD_W-1:`WDC_MEM_LSB]};
              end
            end
          end
        end
        default: begin
          d.phase = wdc_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // State register; reset restores every default
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory write buffer; a slow consumer stalls the pending word
  // The pending register in front keeps the serial side free of back-pressure
  wdc_fifo #(
    .WIDTH(`WDC_FIFO_W),
    .DEPTH(`WDC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_valid(q.pend_valid),
    .o_ready(fifo_in_ready),
    .i_data(q.pend_word),
    .o_valid(o_mem_valid),
    .i_ready(i_mem_ready),
    .o_data(fifo_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_mem_addr = fifo_out[`WDC_FIFO_W-1:`WDC_MEM_DW];
  assign o_mem_data = fifo_out[`WDC_MEM_DW-1:0];
  assign o_mem_overflow = q.ovf;
  assign o_active_regs = q.active;
  assign o_update_armed = q.armed;
  // Both pins share one bit register; only the enables choose the pin
  assign o_sdio = q.dout;
  assign o_multipurpose_serial_pin = q.dout;
  // Line is driven only in the data phase of a read
  assign o_sdio_oe = frame_on & (q.phase == wdc_pkg::PH_DATA) & q.rw & ~use_mpin;
  assign o_multipurpose_serial_pin_oe = frame_on & (q.phase == wdc_pkg::PH_DATA) &
                                        q.rw & use_mpin;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // All checks run on the core clock and stay quiet while reset is held
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  a_cs_ends_frame: assert property (q.cs_s2 |=> q.phase == wdc_pkg::PH_IDLE)
    else $error("frame not ended by chip select");
  a_idle_no_drive: assert property (q.cs_s2 |-> !o_sdio_oe && !o_multipurpose_serial_pin_oe)
    else $error("pin driven outside a frame");
  a_header_latch: assert property (hdr_done |=> q.phase == wdc_pkg::PH_DATA &&
    q.addr == $past(hdr_addr) && q.rw == $past(q.shreg[14]) && q.bitcnt == 5'h00)
    else $error("header not latched");
  a_write_no_drive: assert property ((q.phase == wdc_pkg::PH_DATA && !q.rw) |->
    !o_sdio_oe && !o_multipurpose_serial_pin_oe)
    else $error("data line driven during write");
  a_read_drive: assert property ((frame_on && q.phase == wdc_pkg::PH_DATA && q.rw) |->
    (o_sdio_oe != o_multipurpose_serial_pin_oe) && (o_multipurpose_serial_pin_oe == use_mpin))
    else $error("read data not driven on the right pin");
  a_msb_first: assert property ((sclk_fall && frame_on && q.phase == wdc_pkg::PH_DATA && q.rw)
    |=> o_sdio == $past(tx_msb))
    else $error("read bit out of order");
  a_addr_incr: assert property (word_done |=> q.addr == $past(addr_next))
    else $error("address did not advance");
  a_dbl_two_bits: assert property ((sclk_rise && frame_on && q.phase == wdc_pkg::PH_DATA &&
    dbl_wr && !word_done) |=> q.bitcnt == $past(q.bitcnt) + 5'h02)
    else $error("double-rate count wrong");
  a_arm_on_write: assert property ((wr_commit && q.addr == `WDC_XFER_ADDR &&
    wr_word[`WDC_UPDATE_BIT]) |=> q.armed)
    else $error("update bit did not arm");
  a_xfer_copy: assert property ((q.armed && i_pattern_off) |=>
    o_active_regs == $past(q.shadow))
    else $error("shadow not copied");
  a_mem_bypass: assert property ((wr_commit && is_mem) |=>
    (q.shadow == $past(q.shadow)) && (q.pend_valid || q.ovf))
    else $error("memory write touched shadow set");

  c_read_burst: cover property (word_done && q.rw ##1 q.phase == wdc_pkg::PH_DATA);
  c_dbl_mem: cover property (wr_commit && is_mem && dbl_wr);
  c_transfer: cover property (q.armed && i_pattern_off);
  c_fifo_stall: cover property (q.pend_valid && !fifo_in_ready);
  c_four_read: cover property (o_multipurpose_serial_pin_oe && sclk_fall);
endmodule

/* tb/wdc_host_model.sv */
`timescale 1ns/1ps
module wdc_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdio,
  output logic o_sdio_en,
  output logic o_mp,
  input wire logic i_sdio,
  input wire logic i_mp
);
  // Idle: serial clock parked low, frame closed, lines released
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdio = 1'b0;
    o_sdio_en = 1'b0;
    o_mp = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One 48 ns serial period; a released line toggles so stale values never pass
  task automatic cycle(input logic drv, input logic d, input logic two, input logic d2,
                       input logic rel, output logic r_sd, output logic r_mp);
    o_sdio_en = drv;
    o_sdio = drv ? d : ~o_sdio;
    o_mp = two ? d2 : ~o_mp;
    #24 o_sclk = 1'b1;
    // Let go early after the last header bit of a read, before the port turns around
    #8 if (rel) begin
      o_sdio_en = 1'b0;
      o_sdio = ~o_sdio;
    end
    #14 r_sd = i_sdio;
    r_mp = i_mp;
    #2 o_sclk = 1'b0;
  endtask

  // Open a frame: direction bit then 15-bit address, MSB first
  task automatic start(input logic rw, input logic [14:0] a);
    logic [15:0] h;
    logic x;
    logic y;
    h = {rw, a};
    o_cs_n = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) cycle(1'b1, h[i], 1'b0, 1'b0, rw && i == 0, x, y);
  endtask

  // One 16-bit word; double rate puts the lower bit of each pair on the second pin
  task automatic word(input logic [15:0] w, input logic two);
    logic x;
    logic y;
    if (two) begin
      for (int i = 15; i > 0; i -= 2) cycle(1'b1, w[i], 1'b1, w[i-1], 1'b0, x, y);
    end else begin
      for (int i = 15; i >= 0; i--) cycle(1'b1, w[i], 1'b0, 1'b0, 1'b0, x, y);
    end
  endtask

  // A few stray bits, used to cut a word short
  task automatic bits(input int n);
    logic x;
    logic y;
    for (int i = 0; i < n; i++) cycle(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, x, y);
  endtask

  // Read one word from the data line or the multipurpose pin
  task automatic rd(input logic four, output logic [15:0] r);
    logic x;
    logic y;
    for (int i = 15; i >= 0; i--) begin
      cycle(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, x, y);
      r[i] = four ? y : x;
    end
  endtask

  // Close the frame and keep chip select high well over one serial period
  task automatic stop();
    #24 o_cs_n = 1'b1;
    o_sdio_en = 1'b0;
    #100;
  endtask
endmodule

/* tb/wdc_spi_port_tb.sv */
`timescale 1ns/1ps
module wdc_spi_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic four = 1'b0;
  logic dbl = 1'b0;
  logic poff = 1'b0;
  logic mrdy = 1'b0;
  logic sclk, cs_n, h_sdio, h_en, h_mp, sdio_o, sdio_oe, mp_o, mp_oe, armed, mval, movf;
  logic sdio_w, mp_w;
  logic [255:0] act;
  logic [11:0] maddr, mdata;
  logic [23:0] q[$];
  int mismatches = 0;
  int comparisons = 0;

  always #2.5 clk = ~clk;

  // Wire level of each shared pin from the port's enable alone; the host value otherwise
  assign sdio_w = sdio_oe ? sdio_o : h_sdio;
  assign mp_w = mp_oe ? mp_o : h_mp;

  wdc_spi_port u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdio(sdio_w), .o_sdio(sdio_o), .o_sdio_oe(sdio_oe), .i_multipurpose_serial_pin(mp_w),
    .o_multipurpose_serial_pin(mp_o), .o_multipurpose_serial_pin_oe(mp_oe),
    .i_four_wire(four), .i_double_rate(dbl), .i_pattern_off(poff), .o_active_regs(act),
    .o_update_armed(armed), .o_mem_valid(mval), .i_mem_ready(mrdy), .o_mem_addr(maddr),
    .o_mem_data(mdata), .o_mem_overflow(movf));

  wdc_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(h_sdio), .o_sdio_en(h_en),
    .o_mp(h_mp), .i_sdio(sdio_w), .i_mp(mp_w));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Memory words taken by the consumer, as {index, entry}; looked at mid-cycle,
  // where both sides have settled for the next accepting edge
  always @(negedge clk) begin
    #1;
    if (mval === 1'b1 && mrdy === 1'b1) q.push_back({maddr, mdata});
  end

  // Two drivers on one line, or the wrong pin driven for the mode; enables settled
  always @(negedge clk) begin
    if (h_en === 1'b1 && sdio_oe === 1'b1) check("sdio_clash", 1, 0);
    if (four === 1'b1 && sdio_oe === 1'b1) check("sdio_in_4wire", 1, 0);
    if (four === 1'b0 && mp_oe === 1'b1) check("mp_in_3wire", 1, 0);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic write_words(input logic [14:0] a, input logic [15:0] w[$], input logic two);
    u_host.start(1'b0, a);
    foreach (w[i]) u_host.word(w[i], two);
    u_host.stop();
  endtask

  task automatic read_check(input logic [14:0] a, input logic [15:0] e[$]);
    logic [15:0] r;
    u_host.start(1'b1, a);
    foreach (e[i]) begin
      u_host.rd(four, r);
      check("read_word", r, e[i]);
    end
    u_host.stop();
  endtask

  // Active set, armed flag, memory valid, both enables and overflow cleared by the reset pin
  task automatic t_reset();
    check("active_regs", act == '0, 1);
    check("armed", armed, 0);
    check("mem_valid", mval, 0);
    check("oe", {sdio_oe, mp_oe, movf}, 0);
  endtask

  // Burst write, a frame cut mid-word, burst read back
  task automatic t_burst();
    write_words(15'h0002, {16'hABCD, 16'h1234}, 1'b0);
    u_host.start(1'b0, 15'h0005);
    u_host.word(16'h5555, 1'b0);
    u_host.bits(7);
    u_host.stop();
    read_check(15'h0002, {16'hABCD, 16'h1234});
    read_check(15'h0005, {16'h5555, 16'h0000});
  endtask

  // Read back through the multipurpose pin
  task automatic t_four();
    @(negedge clk) four = 1'b1;
    read_check(15'h0003, {16'h1234});
    @(negedge clk) four = 1'b0;
  endtask

  // Arm while the pattern runs, copy once it stops
  task automatic t_xfer();
    write_words(15'h001D, {16'h0001}, 1'b0);
    check("armed_set", armed, 1);
    check("active_held", act[47:32], 16'h0000);
    @(negedge clk) poff = 1'b1;
    repeat (3) @(negedge clk);
    check("armed_clear", armed, 0);
    check("active_2", act[47:32], 16'hABCD);
    check("active_3", act[63:48], 16'h1234);
    check("active_5", act[95:80], 16'h5555);
    check("no_mem_word", q.size(), 0);
  endtask

  // Double-rate load at the top of the memory window
  task automatic t_mem();
    @(negedge clk) mrdy = 1'b1;
    dbl = 1'b1;
    write_words(15'h6FFE, {16'hABC5, 16'h1237}, 1'b1);
    @(negedge clk) dbl = 1'b0;
    check("mem_count", q.size(), 2);
    check("mem_0", q[0], 24'hFFEABC);
    check("mem_1", q[1], 24'hFFF123);
  endtask

  // Fill the buffer with the consumer stalled, then drain it empty
  task automatic t_fill();
    logic [15:0] w[$];
    for (int i = 0; i < 18; i++) w.push_back({12'h800 + 12'(i), 4'h3});
    q.delete();
    @(negedge clk) mrdy = 1'b0;
    write_words(15'h6000, w, 1'b0);
    check("full_valid", mval, 1);
    check("overflow", movf, 1);
    @(negedge clk) mrdy = 1'b1;
    repeat (30) @(negedge clk);
    check("drained", mval, 0);
    check("fill_count", q.size(), 17);
    for (int i = 0; i < 17; i++) check("fill_word", q[i], {12'(i), 12'h800 + 12'(i)});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_burst();
    t_four();
    t_xfer();
    t_mem();
    t_fill();
    tally_and_finish();
  end

  // Whole run needs well under 60 us of serial traffic
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
